/* File: common/lbc_pkg.sv */
/*
  constants, field layouts and types shared by the led boost controller.
  assumes a 100 MHz pclk; all durations are derived from CLK_PERIOD_NS.
*/
// Notes on behaviour
// - close boost switch when feedback below reference
// - open boost switch at peak current limit
// - open boost switch after maximum on time
// - keep open min off time, then await feedback
// - softstart: quarter, half, then full threshold
// - enable after control high long enough, softstart
// - long control low: shutdown, LED switch open
// - enabled: LED switch follows control input directly
// - ignore feedback briefly after LED switch closes
// - optional early shutdown after shorter low phase
// - overvoltage holds boost switch open
// - undervoltage: both switches open, device off
// - overtemperature: both switches open
package lbc_pkg;

  localparam int CLK_PERIOD_NS = 10;

  localparam int MAX_ON_NS     = 6000;
  localparam int MIN_OFF_NS    = 400;
  localparam int BLANK_NS      = 400;
  localparam int EN_HIGH_NS    = 50000;
  localparam int OFF_LOW_NS    = 32000000;
  localparam int EARLY_LOW_NS  = 10000000;

  // longest time rounds down, least times round up
  localparam int MAX_ON_CYC    = MAX_ON_NS / CLK_PERIOD_NS;
  localparam int MIN_OFF_CYC   = (MIN_OFF_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int EN_HIGH_CYC   = (EN_HIGH_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int OFF_LOW_CYC   = (OFF_LOW_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int EARLY_LOW_CYC = (EARLY_LOW_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;

  localparam int SS_STEP_CYCLES = 256;
  localparam int SS_DONE_CYCLES = 512;

  localparam int ON_W  = 10;
  localparam int OFF_W = 6;
  localparam int SS_W  = 10;
  localparam int DUR_W = 22;

  localparam logic [1:0] THR_QUARTER = 2'h0;
  localparam logic [1:0] THR_HALF    = 2'h1;
  localparam logic [1:0] THR_FULL    = 2'h2;

  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] SSCNT_OFS  = 12'h008;

  localparam int CTRL_EARLY_BIT   = 0;
  localparam int CTRL_INHIBIT_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  localparam int ST_ENABLED_BIT = 0;
  localparam int ST_BOOST_BIT   = 1;
  localparam int ST_LED_BIT     = 2;
  localparam int ST_THR_LSB     = 3;
  localparam int ST_STATE_LSB   = 5;
  localparam int ST_FLAGS_LSB   = 8;

  typedef enum logic [1:0] {
    BST_IDLE,
    BST_ON,
    BST_MINOFF
  } lbc_state_type;

endpackage

/* File: src/lbc_sync.sv */
/*
  two flip-flop synchroniser for a vector of slow asynchronous flags.
  assumes each bit is independent; no word coherence is given.
*/
`timescale 1ns/100ps
module lbc_sync #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } lbc_sync_type;

  lbc_sync_type sync_reg;
  lbc_sync_type sync_next;

  always_comb begin
    sync_next.meta = d;
    sync_next.q    = sync_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.q;

endmodule

/* File: src/lbc_ctrl_decode.sv */
/*
  decodes the single control input into an enable level by measuring
  minimum high and low durations. assumes ctrl is already synchronised.
*/
`timescale 1ns/100ps
module lbc_ctrl_decode
  import lbc_pkg::*;
#(
  parameter int EN_CYC    = EN_HIGH_CYC,
  parameter int OFF_CYC   = OFF_LOW_CYC,
  parameter int EARLY_CYC = EARLY_LOW_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ctrl_s,
  input  wire logic early_off,
  input  wire logic lockout,
  output logic      enabled
);

  typedef struct packed {
    logic [DUR_W-1:0] hi_cnt;
    logic [DUR_W-1:0] lo_cnt;
    logic             enabled;
  } lbc_dec_type;

  lbc_dec_type dec_reg;
  lbc_dec_type dec_next;
  logic [DUR_W-1:0] lo_limit;

  always_comb begin
    dec_next = dec_reg;
    lo_limit = early_off ? DUR_W'(EARLY_CYC - 1) : DUR_W'(OFF_CYC - 1);
    if (lockout) begin
      dec_next = '0;
    end else if (ctrl_s) begin
      dec_next.lo_cnt = '0;
      if (!dec_reg.enabled) begin
        if (dec_reg.hi_cnt == DUR_W'(EN_CYC - 1)) begin
          dec_next.enabled = 1'b1;
        end else begin
          dec_next.hi_cnt = dec_reg.hi_cnt + 1'b1;
        end
      end
    end else begin
      dec_next.hi_cnt = '0;
      if (dec_reg.enabled) begin
        if (dec_reg.lo_cnt >= lo_limit) begin
          dec_next.enabled = 1'b0;
          dec_next.lo_cnt  = '0;
        end else begin
          dec_next.lo_cnt = dec_reg.lo_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign enabled = dec_reg.enabled;

endmodule

/* File: src/lbc_top.sv */
/*
  pfm peak-current boost control with softstart, control input decode,
  led return switch drive and an apb register slave.
  assumes comparator flags arrive asynchronously and are resynchronised.
*/
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
module lbc_top
  import lbc_pkg::*;
#(
  parameter int EN_CYC    = EN_HIGH_CYC,
  parameter int OFF_CYC   = OFF_LOW_CYC,
  parameter int EARLY_CYC = EARLY_LOW_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        control_input,
  input  wire logic        sense_feedback_input,
  input  wire logic        current_at_limit,
  input  wire logic        output_overvolt_guard,
  input  wire logic        input_undervolt,
  input  wire logic        over_temperature,
  output logic             boost_power_switch,
  output logic             led_return_switch,
  output logic      [1:0]  peak_current_threshold
);

  typedef struct packed {
    lbc_state_type     state;
    logic [ON_W-1:0]   on_cnt;
    logic [OFF_W-1:0]  off_cnt;
    logic [OFF_W-1:0]  blank_cnt;
    logic [SS_W-1:0]   ss_cnt;
    logic              boost;
    logic              led;
    logic [1:0]        thr;
    logic [1:0]        ctrl;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } lbc_core_type;

  lbc_core_type core_reg;
  lbc_core_type core_next;

  logic [5:0] flags_s;
  logic       ctrl_s;
  logic       fb_s;
  logic       peak_current_threshold_s;
  logic       ovp_s;
  logic       uvlo_s;
  logic       otp_s;
  logic       enabled;
  logic       allowed;
  logic       fb_ok;
  logic       setup;
  logic       access;

  lbc_sync #(
    .W (6)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({over_temperature, input_undervolt, output_overvolt_guard,
               current_at_limit, sense_feedback_input, control_input}),
    .q       (flags_s)
  );

  assign ctrl_s = flags_s[0];
  assign fb_s   = flags_s[1];
  assign peak_current_threshold_s = flags_s[2];
  assign ovp_s  = flags_s[3];
  assign uvlo_s = flags_s[4];
  assign otp_s  = flags_s[5];

  // undervoltage drops the enable so a fresh enable time is needed
  lbc_ctrl_decode #(
    .EN_CYC    (EN_CYC),
    .OFF_CYC   (OFF_CYC),
    .EARLY_CYC (EARLY_CYC)
  ) u_decode (
    .pclk      (pclk),
    .presetn   (presetn),
    .ctrl_s    (ctrl_s),
    .early_off (core_reg.ctrl[CTRL_EARLY_BIT]),
    .lockout   (uvlo_s),
    .enabled   (enabled)
  );

  assign setup  = psel && !penable;
  assign access = psel && penable && core_reg.pready;

  always_comb begin
    core_next = core_reg;
    allowed   = enabled && !uvlo_s && !otp_s && !ovp_s &&
                !core_reg.ctrl[CTRL_INHIBIT_BIT];

    core_next.led = enabled && ctrl_s && !uvlo_s && !otp_s;

    // settle time for the sense voltage after each led turn-on
    if (core_next.led && !core_reg.led) begin
      core_next.blank_cnt = OFF_W'(BLANK_CYC);
    end else if (core_reg.blank_cnt != '0) begin
      core_next.blank_cnt = core_reg.blank_cnt - 1'b1;
    end
    // no closing on the very edge that closes the led switch
    fb_ok = fb_s && (core_reg.blank_cnt == '0) &&
            !(core_next.led && !core_reg.led);

    case (core_reg.state)
      BST_IDLE: begin
        core_next.boost = 1'b0;
        if (allowed && fb_ok) begin
          core_next.state  = BST_ON;
          core_next.boost  = 1'b1;
          core_next.on_cnt = '0;
          if (core_reg.ss_cnt != SS_W'(SS_DONE_CYCLES)) begin
            core_next.ss_cnt = core_reg.ss_cnt + 1'b1;
          end
        end
      end
      BST_ON: begin
        core_next.on_cnt = core_reg.on_cnt + 1'b1;
        if (!allowed || peak_current_threshold_s ||
            core_reg.on_cnt == ON_W'(MAX_ON_CYC - 1)) begin
          core_next.state   = BST_MINOFF;
          core_next.boost   = 1'b0;
          core_next.off_cnt = '0;
        end
      end
      BST_MINOFF: begin
        core_next.boost   = 1'b0;
        core_next.off_cnt = core_reg.off_cnt + 1'b1;
        if (core_reg.off_cnt == OFF_W'(MIN_OFF_CYC - 1)) begin
          core_next.state = BST_IDLE;
        end
      end
      default: begin
        core_next.state = BST_IDLE;
        core_next.boost = 1'b0;
      end
    endcase

    if (!enabled) begin
      core_next.ss_cnt = '0;
    end

    if (core_next.ss_cnt < SS_W'(SS_STEP_CYCLES)) begin
      core_next.thr = THR_QUARTER;
    end else if (core_next.ss_cnt < SS_W'(SS_DONE_CYCLES)) begin
      core_next.thr = THR_HALF;
    end else begin
      core_next.thr = THR_FULL;
    end

    // zero-wait slave: answer prepared in the setup cycle
    core_next.pready  = setup;
    core_next.pslverr = 1'b0;
    core_next.prdata  = '0;
    if (setup) begin
      case (paddr)
        CTRL_OFS: begin
          core_next.prdata[1:0] = core_reg.ctrl;
        end
        STATUS_OFS: begin
          core_next.prdata[ST_ENABLED_BIT] = enabled;
          core_next.prdata[ST_BOOST_BIT]   = core_reg.boost;
          core_next.prdata[ST_LED_BIT]     = core_reg.led;
          core_next.prdata[ST_THR_LSB+:2]  = core_reg.thr;
          core_next.prdata[ST_STATE_LSB+:2] = core_reg.state;
          core_next.prdata[ST_FLAGS_LSB+:5] =
            {otp_s, uvlo_s, ovp_s, peak_current_threshold_s, fb_s};
        end
        SSCNT_OFS: begin
          core_next.prdata[SS_W-1:0] = core_reg.ss_cnt;
        end
        default: begin
          core_next.pslverr = 1'b1;
        end
      endcase
    end
    if (access && pwrite && paddr == CTRL_OFS) begin
      core_next.ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reg      <= '0;
      core_reg.ctrl <= CTRL_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  assign pready                 = core_reg.pready;
  assign prdata                 = core_reg.prdata;
  assign pslverr                = core_reg.pslverr;
  assign boost_power_switch     = core_reg.boost;
  assign led_return_switch      = core_reg.led;
  assign peak_current_threshold = core_reg.thr;

  localparam int A_MAX_ON = 600;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  max_on_time_a: assert property (
    $rose(core_reg.boost) |-> ##[1:A_MAX_ON] !core_reg.boost)
    else $error("boost switch on longer than maximum on time");

  min_off_time_a: assert property (
    $fell(core_reg.boost) |-> (!core_reg.boost)[*8] ##1
      (core_reg.off_cnt != '0 || core_reg.state != BST_IDLE))
    else $error("boost switch reclosed before minimum off time");

  peak_limit_a: assert property (
    (core_reg.state == BST_ON && peak_current_threshold_s) |=> !core_reg.boost)
    else $error("boost switch stayed closed at current limit");

  ovp_hold_a: assert property (
    ovp_s |=> !$rose(core_reg.boost))
    else $error("boost switch closed during overvoltage");

  uvlo_off_a: assert property (
    uvlo_s |=> !core_reg.led && !$rose(core_reg.boost))
    else $error("switch closed during undervoltage");

  otp_off_a: assert property (
    otp_s |=> !core_reg.led && !$rose(core_reg.boost))
    else $error("switch closed during overtemperature");

  softstart_step_a: assert property (
    (core_reg.ss_cnt < SS_W'(SS_STEP_CYCLES)) == (core_reg.thr == THR_QUARTER))
    else $error("threshold step does not match softstart count");

  blank_window_a: assert property (
    $rose(core_reg.led) |-> (!$rose(core_reg.boost))[*8])
    else $error("feedback acted during blanking");

  led_follow_a: assert property (
    (enabled && ctrl_s && !uvlo_s && !otp_s) |=> core_reg.led)
    else $error("led switch did not follow control input");

  restart_a: assert property (
    !enabled |=> core_reg.ss_cnt == '0)
    else $error("softstart count not cleared while disabled");

  led_shutdown_a: assert property (
    !enabled |=> !core_reg.led)
    else $error("led switch closed while disabled");

  close_on_fb_a: assert property (
    (core_reg.state == BST_IDLE && !fb_s) |=> !core_reg.boost)
    else $error("boost switch closed without low feedback");

  close_enabled_a: assert property (
    !enabled |=> !$rose(core_reg.boost))
    else $error("boost switch closed while disabled");

  blank_load_a: assert property (
    $rose(core_reg.led) |-> core_reg.blank_cnt == OFF_W'(BLANK_CYC))
    else $error("blanking not started at led turn-on");

  blank_gate_a: assert property (
    core_reg.blank_cnt != '0 |=> !$rose(core_reg.boost))
    else $error("boost switch closed inside blanking");

  minoff_open_a: assert property (
    core_reg.state == BST_MINOFF |-> !core_reg.boost)
    else $error("boost switch closed in minimum off time");

  open_to_minoff_a: assert property (
    $fell(core_reg.boost) |-> core_reg.state == BST_MINOFF)
    else $error("boost switch opened without minimum off time");

  on_count_a: assert property (
    core_reg.boost |-> core_reg.on_cnt < ON_W'(MAX_ON_CYC))
    else $error("on time count beyond maximum");

  full_step_a: assert property (
    (core_reg.ss_cnt >= SS_W'(SS_DONE_CYCLES)) ==
      (core_reg.thr == THR_FULL))
    else $error("full threshold does not match softstart count");

  ss_saturate_a: assert property (
    core_reg.ss_cnt <= SS_W'(SS_DONE_CYCLES))
    else $error("softstart count beyond saturation");

  led_follow_low_a: assert property (
    !ctrl_s |=> !core_reg.led)
    else $error("led switch closed with control input low");

endmodule

/* File: verif/lbc_host_model.sv */
/*
  host side pwm source for the control input.
  assumes pclk from the bench; pin held low while not running.
*/
`timescale 1ns/100ps
module lbc_host_model (
  input  wire logic        pclk,
  input  wire logic        run,
  input  wire logic [15:0] high_cyc,
  input  wire logic [15:0] low_cyc,
  output logic             control_input
);
  logic [15:0] cnt_reg  = 16'h0000;
  logic        ctrl_reg = 1'b0;

  // zero low time gives a steady high, a plain enable
  // widths stay far above the pulse minimum and the rate below switching
  always @(posedge pclk) begin
    if (!run || cnt_reg >= high_cyc + low_cyc - 16'h0001)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_reg + 16'h0001;
    ctrl_reg <= run && (cnt_reg < high_cyc);
  end

  assign control_input = ctrl_reg;
endmodule

/* File: verif/tb_top.sv */
/*
  self-checking bench for the led boost controller top.
  assumes lbc_pkg and the host model are compiled first.
*/
`timescale 1ns/100ps
module tb_top
  import lbc_pkg::*;
;
  localparam int EN = 50;
  localparam int OFF = 3000;
  localparam int EARLY = 1500;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        control_input, run, auto, peak_current_threshold_man;
  logic        b_q = 1'b0;
  logic        current_at_limit = 1'b0;
  logic        sense_feedback_input;
  logic        output_overvolt_guard, input_undervolt, over_temperature;
  logic        boost_power_switch, led_return_switch;
  logic [1:0]  peak_current_threshold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] hi, lo;
  logic [2:0]  hist = 3'h0;
  int          n_fail, check_count, n, bad;
  int          cyc = 0;
  int          closes = 0;

  lbc_top #(.EN_CYC(EN), .OFF_CYC(OFF), .EARLY_CYC(EARLY)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .control_input(control_input),
    .sense_feedback_input(sense_feedback_input),
    .current_at_limit(current_at_limit),
    .output_overvolt_guard(output_overvolt_guard),
    .input_undervolt(input_undervolt),
    .over_temperature(over_temperature),
    .boost_power_switch(boost_power_switch),
    .led_return_switch(led_return_switch),
    .peak_current_threshold(peak_current_threshold));

  lbc_host_model host (.pclk(pclk), .run(run), .high_cyc(hi),
    .low_cyc(lo), .control_input(control_input));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // auto mode: current limit answers each closing, a crude inductor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    b_q <= boost_power_switch;
    hist <= {hist[1:0], control_input};
    current_at_limit <= auto ? boost_power_switch : peak_current_threshold_man;
    if (boost_power_switch && !b_q)
      closes <= closes + 1;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rng(input int a, input int b);
    chk((n >= a && n <= b) ? 32'(n) : 32'hFFFF_FFFF, 32'(n));
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20)
      n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r & m, x);
  endtask

  task automatic await(input int s, input logic v, input int lim);
    n = 0;
    while ((s == 0 ? boost_power_switch : led_return_switch) !== v &&
           n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic wait_closes(input int k);
    n = 0;
    while (closes < k && n < 30000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic thr_is(input logic [1:0] t);
    chk(32'(peak_current_threshold), 32'(t));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, run, auto, peak_current_threshold_man} = 7'h00;
    {sense_feedback_input, output_overvolt_guard} = 2'h0;
    {input_undervolt, over_temperature} = 2'h0;
    {paddr, pwdata, hi, lo} = 76'h0;
    {n_fail, check_count} = 64'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(led_return_switch), 32'h0000_0000);
    rdchk(CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    $display("reset test done");
    hi <= 16'hFFFF;
    run <= 1'b1;
    await(1, 1'b1, 100);
    rng(EN, EN + 8);
    rdchk(STATUS_OFS, 32'h0000_0019, 32'h0000_0001);
    @(posedge pclk);
    sense_feedback_input <= 1'b1;
    await(0, 1'b1, 60);
    rng(30, 45);
    @(posedge pclk);
    peak_current_threshold_man <= 1'b1;
    await(0, 1'b0, 10);
    rng(1, 8);
    @(posedge pclk);
    peak_current_threshold_man <= 1'b0;
    await(0, 1'b1, 80);
    rng(34, 46);
    await(0, 1'b0, 700);
    rng(590, 605);
    await(0, 1'b1, 80);
    @(posedge pclk);
    output_overvolt_guard <= 1'b1;
    await(0, 1'b0, 10);
    rng(1, 7);
    await(0, 1'b1, 100);
    rng(100, 100);
    output_overvolt_guard <= 1'b0;
    await(0, 1'b1, 20);
    rng(1, 8);
    $display("boost test done");
    auto <= 1'b1;
    wait_closes(255);
    thr_is(THR_QUARTER);
    wait_closes(256);
    repeat (3) @(posedge pclk);
    thr_is(THR_HALF);
    wait_closes(511);
    thr_is(THR_HALF);
    wait_closes(520);
    thr_is(THR_FULL);
    rdchk(SSCNT_OFS, 32'h0000_03FF, 32'h0000_0200);
    auto <= 1'b0;
    sense_feedback_input <= 1'b0;
    $display("softstart test done");
    hi <= 16'd1000;
    lo <= 16'd1000;
    bad = 0;
    repeat (4000) begin
      @(posedge pclk);
      if (led_return_switch !== hist[2])
        bad++;
    end
    chk(32'(bad), 32'h0000_0000);
    await(1, 1'b1, 1100);
    run <= 1'b0;
    repeat (OFF - 100) @(posedge pclk);
    rdchk(STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    repeat (150) @(posedge pclk);
    rdchk(STATUS_OFS, 32'h0000_0005, 32'h0000_0000);
    {hi, lo} <= {16'hFFFF, 16'h0000};
    run <= 1'b1;
    await(1, 1'b1, 100);
    rng(EN, EN + 8);
    rdchk(SSCNT_OFS, 32'h0000_03FF, 32'h0000_0000);
    rdchk(STATUS_OFS, 32'h0000_0018, 32'h0000_0000);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    run <= 1'b0;
    repeat (EARLY - 100) @(posedge pclk);
    rdchk(STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    repeat (150) @(posedge pclk);
    rdchk(STATUS_OFS, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    run <= 1'b1;
    sense_feedback_input <= 1'b1;
    await(1, 1'b1, 100);
    $display("control test done");
    @(posedge pclk);
    input_undervolt <= 1'b1;
    await(1, 1'b0, 8);
    rng(1, 6);
    repeat (3) @(posedge pclk);
    chk(32'(boost_power_switch), 32'h0000_0000);
    input_undervolt <= 1'b0;
    await(1, 1'b1, 100);
    rng(EN, EN + 8);
    @(posedge pclk);
    over_temperature <= 1'b1;
    await(1, 1'b0, 8);
    rng(1, 6);
    repeat (3) @(posedge pclk);
    chk(32'(boost_power_switch), 32'h0000_0000);
    over_temperature <= 1'b0;
    await(1, 1'b1, 10);
    rng(1, 6);
    $display("fault test done");
    tally_and_finish();
  end
endmodule
